// ---- hdl/rpmlk_pkg.sv ----
// Constants, field layouts and carrier types for the remappable pin output mux.
// Assumes one 20 MHz clock and a 16-bit plain register port with 4-bit word addresses.
`default_nettype none

package rpmlk_pkg;

    localparam int PIN_COUNT      = 8;
    localparam int PIN_IDX_W      = 3;
    localparam int SEL_W          = 5;
    localparam int DATA_W         = 16;
    localparam int ADDR_W         = 4;
    localparam int OUT_REG_COUNT  = 4;
    localparam int IN_REG_COUNT   = 2;
    localparam int IN_FIELD_COUNT = 4;
    localparam int IRQ_W          = 5;
    localparam int CFG_W          = 8;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_OSC_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OUT_MAP0   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IN_MAP0    = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_ANALOG     = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_PIN_READ   = 4'ha;

    // Field positions
    localparam int LOCK_BIT        = 6;
    localparam int ONE_WAY_BIT     = 5;
    localparam int LOCK_SEEN_BIT   = 4;
    localparam int FIELD_LO_POS    = 0;
    localparam int FIELD_HI_POS    = 8;
    localparam int FIELD_STRIDE    = 8;

    // Unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;

    // Output selector codes and the input ground code
    localparam logic [SEL_W-1:0] SEL_NULL       = 5'h00;
    localparam logic [SEL_W-1:0] SEL_SERIAL_TX  = 5'h03;
    localparam logic [SEL_W-1:0] SEL_SERIAL_RTS = 5'h04;
    localparam logic [SEL_W-1:0] SEL_SPI_DATA   = 5'h07;
    localparam logic [SEL_W-1:0] SEL_SPI_CLOCK  = 5'h08;
    localparam logic [SEL_W-1:0] SEL_SPI_SELECT = 5'h09;
    localparam logic [SEL_W-1:0] SEL_COMPARE_A  = 5'h12;
    localparam logic [SEL_W-1:0] SEL_COMPARE_B  = 5'h13;
    localparam logic [SEL_W-1:0] IN_SEL_GROUND  = 5'h1f;

    // Reset values and write masks
    localparam logic [DATA_W-1:0]    OUT_MAP_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0]    IN_MAP_RESET   = 16'h1f1f;
    localparam logic [DATA_W-1:0]    MAP_FIELD_MASK = 16'h1f1f;
    localparam logic [PIN_COUNT-1:0] ANALOG_RESET   = 8'hff;
    localparam logic [IRQ_W-1:0]     IRQ_RESET      = 5'h00;

    // Interrupt status bit positions
    localparam int IRQ_LOCKED_WRITE = 0;
    localparam int IRQ_LOCK_CHANGED = 1;
    localparam int IRQ_LOCK_REFUSED = 2;
    localparam int IRQ_MISMATCH     = 3;
    localparam int IRQ_KEY_CANCEL   = 4;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b10
    } rpmlk_key_t;

    // Outputs of the on-chip peripherals, candidates for a pin
    typedef struct packed {
        logic serial_tx_out;
        logic serial_rts_out;
        logic spi_data_out;
        logic spi_clock_out;
        logic spi_select_out;
        logic compare_out_a;
        logic compare_out_b;
    } rpmlk_periph_out_t;

    // Peripheral inputs fed from a selected pin
    typedef struct packed {
        logic serial_rx;
        logic spi_data_in;
        logic spi_clock_in;
        logic spi_select_in;
    } rpmlk_periph_in_t;

    typedef struct packed {
        logic [OUT_REG_COUNT-1:0][DATA_W-1:0] out_map;
        logic [OUT_REG_COUNT-1:0][DATA_W-1:0] out_shadow;
        logic [IN_REG_COUNT-1:0][DATA_W-1:0]  in_map;
        logic [IN_REG_COUNT-1:0][DATA_W-1:0]  in_shadow;
        logic                                 lock;
        logic                                 lock_seen;
        rpmlk_key_t                           key;
        logic [2:0][PIN_COUNT-1:0]            pad_sync;
        logic [PIN_COUNT-1:0]                 pad_filt;
        logic [2:0]                           cfg_sync;
        logic                                 one_way;
        logic [PIN_COUNT-1:0]                 analog;
        logic [IRQ_W-1:0]                     status;
        logic [IRQ_W-1:0]                     mask;
        logic [DATA_W-1:0]                    rdata;
        logic [PIN_COUNT-1:0]                 pin_val;
        logic [PIN_COUNT-1:0]                 pin_oe;
        logic [PIN_COUNT-1:0]                 pin_read;
        rpmlk_periph_in_t                     to_periph;
        logic                                 irq;
        logic                                 mismatch;
    } rpmlk_state_t;

endpackage

`default_nettype wire

// ---- hdl/rpmlk_pin_drive.sv ----
// One pad's output selection: analog, then remapped peripheral, then default port.
// Purely combinational; the caller registers the result.
`default_nettype none

module rpmlk_pin_drive
    import rpmlk_pkg::*;
(
    // Selection
    input  wire logic [SEL_W-1:0]  sel_in,
    input  wire logic              analog_in,
    // Sources
    input  wire rpmlk_periph_out_t periph_in,
    input  wire logic              port_data_in,
    input  wire logic              direction_in,
    // Pad drive
    output logic                   val_out,
    output logic                   oe_out
);

    logic hit;
    logic pv;

    always_comb begin
        hit = 1'b1;
        pv  = 1'b0;
        case (sel_in)
            SEL_SERIAL_TX:  pv = periph_in.serial_tx_out;
            SEL_SERIAL_RTS: pv = periph_in.serial_rts_out;
            SEL_SPI_DATA:   pv = periph_in.spi_data_out;
            SEL_SPI_CLOCK:  pv = periph_in.spi_clock_out;
            SEL_SPI_SELECT: pv = periph_in.spi_select_out;
            SEL_COMPARE_A:  pv = periph_in.compare_out_a;
            SEL_COMPARE_B:  pv = periph_in.compare_out_b;
            default:        hit = 1'b0;
        endcase
        if (analog_in) begin
            // Analog owns the pad; digital drive is held off
            val_out = 1'b0;
            oe_out  = 1'b0;
        end else if (hit) begin
            val_out = pv;
            oe_out  = 1'b1;
        end else begin
            val_out = port_data_in;
            oe_out  = ~direction_in;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/rpmlk_top.sv ----
// Remappable pin output mux with write lock, unlock key, one-way lock and shadow check.
// Assumes a 20 MHz clk_in, a plain register port and pads sampled from outside the domain.
//
// Contract
// - Each remappable pin has its own 5-bit selector choosing the peripheral that drives it.
// - Selector zero leaves the pin with its default port function.
// - Code 00011 drives the serial transmitter and code 00100 the serial request-to-send.
// - Codes 00111, 01000 and 01001 drive SPI data, SPI clock and SPI select outputs.
// - Codes 10010 and 10011 drive the first and second compare outputs.
// - While locked, writes to mapping registers complete but change nothing.
// - The lock is bit 6 of the oscillator control register; one blocks, zero permits.
// - Lock changes are taken only after 0x46 then 0x57 are written to the low byte.
// - The lock holds its value until changed and never re-locks by itself.
// - Shadow copies of the mapping registers are compared always; a mismatch fires a reset.
// - With the one-way bit 5 of the configuration word set, a set lock cannot be cleared.
// - The one-way bit defaults to set; when clear, any number of unlock sessions work.
// - Analog-capable pins come up analog after reset and read as 0 digitally.
// - The highest-priority enabled function owns a pin and suppresses those below.
// - Input selector n routes pin n to a peripheral input, all-ones ties it to ground.
`default_nettype none

module rpmlk_top
    import rpmlk_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    // Register port
    input  wire logic [ADDR_W-1:0]    addr_in,
    input  wire logic [DATA_W-1:0]    wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [DATA_W-1:0]    rdata_out,
    // Oscillator configuration word
    input  wire logic [CFG_W-1:0]     osc_config_word_in,
    // Peripheral side
    input  wire rpmlk_periph_out_t    periph_outputs_in,
    output rpmlk_periph_in_t          periph_inputs_out,
    // Default port side
    input  wire logic [PIN_COUNT-1:0] port_data_in,
    input  wire logic [PIN_COUNT-1:0] direction_reg_in,
    output logic      [PIN_COUNT-1:0] pin_read_out,
    // Pads
    input  wire logic [PIN_COUNT-1:0] pad_in,
    output logic      [PIN_COUNT-1:0] pad_out,
    output logic      [PIN_COUNT-1:0] pad_oe_out,
    // Events
    output logic                      irq_out,
    output logic                      mismatch_reset_out
);

    rpmlk_state_t r;
    rpmlk_state_t next_r;

    logic [PIN_COUNT-1:0] mux_val;
    logic [PIN_COUNT-1:0] mux_oe;

    // One selector field per pin, two pins to a register
    genvar k;
    generate
        for (k = 0; k < PIN_COUNT; k = k + 1) begin : g_pin
            rpmlk_pin_drive u_drive (
                .sel_in       (r.out_map[k/2][(k%2)*FIELD_STRIDE +: SEL_W]),
                .analog_in    (r.analog[k]),
                .periph_in    (periph_outputs_in),
                .port_data_in (port_data_in[k]),
                .direction_in (direction_reg_in[k]),
                .val_out      (mux_val[k]),
                .oe_out       (mux_oe[k])
            );
        end
    endgenerate

    function automatic logic pick_pin(input logic [SEL_W-1:0]     sel,
                                      input logic [PIN_COUNT-1:0] pins);
        logic res;
        res = 1'b0;
        // Ground code and out-of-range pins both read as zero
        if (sel != IN_SEL_GROUND && sel < SEL_W'(PIN_COUNT)) begin
            res = pins[sel[PIN_IDX_W-1:0]];
        end
        return res;
    endfunction

    logic [IRQ_W-1:0]          set_ev;
    logic                      osc_wr;
    logic                      any_acc;
    logic                      map_hit;
    logic [PIN_COUNT-1:0]      agree;
    logic [PIN_COUNT-1:0]      dig_pins;
    logic [IN_FIELD_COUNT-1:0] in_vec;
    logic [DATA_W-1:0]         rd_mux;
    logic [SEL_W-1:0]          fld;

    always_comb begin
        next_r   = r;
        set_ev   = '0;
        map_hit  = 1'b0;
        rd_mux   = '0;
        in_vec   = '0;
        fld      = '0;
        osc_wr   = wr_in && (addr_in == ADDR_OSC_CTRL);
        any_acc  = wr_in || rd_in;

        // Pad and strap synchronisers; a change counts once stages two and three agree
        next_r.pad_sync = {r.pad_sync[1], r.pad_sync[0], pad_in};
        agree           = ~(r.pad_sync[1] ^ r.pad_sync[2]);
        next_r.pad_filt = (r.pad_filt & ~agree) | (r.pad_sync[2] & agree);
        next_r.cfg_sync = {r.cfg_sync[1], r.cfg_sync[0], osc_config_word_in[ONE_WAY_BIT]};
        if (r.cfg_sync[1] == r.cfg_sync[2]) begin
            next_r.one_way = r.cfg_sync[2];
        end

        // Unlock key sequencer
        case (r.key)
            KEY_IDLE: begin
                if (osc_wr && wdata_in[7:0] == KEY_FIRST) begin
                    next_r.key = KEY_HALF;
                end
            end
            KEY_HALF: begin
                if (osc_wr && wdata_in[7:0] == KEY_SECOND) begin
                    next_r.key = KEY_ARMED;
                end else if (osc_wr && wdata_in[7:0] == KEY_FIRST) begin
                    next_r.key = KEY_HALF;
                end else if (any_acc) begin
                    next_r.key = KEY_IDLE;
                    set_ev[IRQ_KEY_CANCEL] = 1'b1;
                end
            end
            KEY_ARMED: begin
                if (osc_wr) begin
                    next_r.key = KEY_IDLE;
                    if (r.one_way && r.lock_seen && !wdata_in[LOCK_BIT]) begin
                        set_ev[IRQ_LOCK_REFUSED] = 1'b1;
                    end else begin
                        next_r.lock = wdata_in[LOCK_BIT];
                        if (wdata_in[LOCK_BIT] != r.lock) begin
                            set_ev[IRQ_LOCK_CHANGED] = 1'b1;
                        end
                    end
                    if (wdata_in[LOCK_BIT]) begin
                        next_r.lock_seen = 1'b1;
                    end
                end else if (any_acc) begin
                    next_r.key = KEY_IDLE;
                    set_ev[IRQ_KEY_CANCEL] = 1'b1;
                end
            end
            default: next_r.key = KEY_IDLE;
        endcase

        // Mapping register writes; shadows follow every accepted write
        for (int i = 0; i < OUT_REG_COUNT; i++) begin
            if (wr_in && addr_in == ADDR_OUT_MAP0 + ADDR_W'(i)) begin
                map_hit = 1'b1;
                if (!r.lock) begin
                    next_r.out_map[i]    = wdata_in & MAP_FIELD_MASK;
                    next_r.out_shadow[i] = wdata_in & MAP_FIELD_MASK;
                end
            end
        end
        for (int i = 0; i < IN_REG_COUNT; i++) begin
            if (wr_in && addr_in == ADDR_IN_MAP0 + ADDR_W'(i)) begin
                map_hit = 1'b1;
                if (!r.lock) begin
                    next_r.in_map[i]    = wdata_in & MAP_FIELD_MASK;
                    next_r.in_shadow[i] = wdata_in & MAP_FIELD_MASK;
                end
            end
        end
        if (map_hit && r.lock) begin
            set_ev[IRQ_LOCKED_WRITE] = 1'b1;
        end

        if (wr_in && addr_in == ADDR_ANALOG) begin
            next_r.analog = wdata_in[PIN_COUNT-1:0];
        end
        if (wr_in && addr_in == ADDR_IRQ_MASK) begin
            next_r.mask = wdata_in[IRQ_W-1:0];
        end

        // Continuous shadow comparison; any disturbance of a stored cell fires
        next_r.mismatch = (r.out_map != r.out_shadow) || (r.in_map != r.in_shadow);
        if (next_r.mismatch) begin
            set_ev[IRQ_MISMATCH] = 1'b1;
        end

        // Read data, valid only in the cycle after the strobe
        case (addr_in)
            ADDR_OSC_CTRL: begin
                rd_mux[LOCK_BIT]      = r.lock;
                rd_mux[ONE_WAY_BIT]   = r.one_way;
                rd_mux[LOCK_SEEN_BIT] = r.lock_seen;
            end
            ADDR_ANALOG:     rd_mux[PIN_COUNT-1:0] = r.analog;
            ADDR_IRQ_STATUS: rd_mux[IRQ_W-1:0]     = r.status;
            ADDR_IRQ_MASK:   rd_mux[IRQ_W-1:0]     = r.mask;
            ADDR_PIN_READ:   rd_mux[PIN_COUNT-1:0] = r.pin_read;
            default: begin
                for (int i = 0; i < OUT_REG_COUNT; i++) begin
                    if (addr_in == ADDR_OUT_MAP0 + ADDR_W'(i)) begin
                        rd_mux = r.out_map[i];
                    end
                end
                for (int i = 0; i < IN_REG_COUNT; i++) begin
                    if (addr_in == ADDR_IN_MAP0 + ADDR_W'(i)) begin
                        rd_mux = r.in_map[i];
                    end
                end
            end
        endcase
        next_r.rdata = rd_in ? rd_mux : '0;

        // Sticky status; a read clears it but an event in the same cycle survives
        if (rd_in && addr_in == ADDR_IRQ_STATUS) begin
            next_r.status = set_ev;
        end else begin
            next_r.status = r.status | set_ev;
        end
        next_r.irq = |(next_r.status & next_r.mask);

        // Digital reads of analog pins return zero
        dig_pins        = r.pad_filt & ~r.analog;
        next_r.pin_read = dig_pins;

        // Input routing: field order serial_rx, spi_data_in, spi_clock_in, spi_select_in
        for (int j = 0; j < IN_FIELD_COUNT; j++) begin
            fld = r.in_map[j/2][(j%2)*FIELD_STRIDE +: SEL_W];
            in_vec[IN_FIELD_COUNT-1-j] = pick_pin(fld, dig_pins);
        end
        next_r.to_periph = rpmlk_periph_in_t'(in_vec);

        // Registered pad drive keeps every pad output glitch-free
        next_r.pin_val = mux_val;
        next_r.pin_oe  = mux_oe;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r.out_map    <= {OUT_REG_COUNT{OUT_MAP_RESET}};
            r.out_shadow <= {OUT_REG_COUNT{OUT_MAP_RESET}};
            r.in_map     <= {IN_REG_COUNT{IN_MAP_RESET}};
            r.in_shadow  <= {IN_REG_COUNT{IN_MAP_RESET}};
            r.lock       <= 1'b0;
            r.lock_seen  <= 1'b0;
            r.key        <= KEY_IDLE;
            r.pad_sync   <= '0;
            r.pad_filt   <= '0;
            r.cfg_sync   <= 3'h7;
            r.one_way    <= 1'b1;
            r.analog     <= ANALOG_RESET;
            r.status     <= IRQ_RESET;
            r.mask       <= IRQ_RESET;
            r.rdata      <= '0;
            r.pin_val    <= '0;
            r.pin_oe     <= '0;
            r.pin_read   <= '0;
            r.to_periph  <= '0;
            r.irq        <= 1'b0;
            r.mismatch   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_out          = r.rdata;
    assign periph_inputs_out  = r.to_periph;
    assign pin_read_out       = r.pin_read;
    assign pad_out            = r.pin_val;
    assign pad_oe_out         = r.pin_oe;
    assign irq_out            = r.irq;
    assign mismatch_reset_out = r.mismatch;

endmodule

`default_nettype wire

// ---- tb/rpmlk_asserts.sv ----
// Checker for the pin output mux: lock bit, unlock key, one-way lock and reset state.
// Sees only top-level ports and is bound into every rpmlk_top instance.
`default_nettype none

module rpmlk_asserts
    import rpmlk_pkg::*;
(
    // Clock and reset
    input wire logic                 clk_in,
    input wire logic                 reset_n_in,
    // Register port
    input wire logic [ADDR_W-1:0]    addr_in,
    input wire logic [DATA_W-1:0]    wdata_in,
    input wire logic                 wr_in,
    input wire logic                 rd_in,
    input wire logic [DATA_W-1:0]    rdata_out,
    // Pins and events
    input wire logic [PIN_COUNT-1:0] pin_read_out,
    input wire logic [PIN_COUNT-1:0] pad_oe_out,
    input wire logic                 mismatch_reset_out
);
    logic rd_osc;
    logic wr_osc;
    logic key_a;
    logic key_b;

    assign rd_osc = rd_in && addr_in == ADDR_OSC_CTRL;
    assign wr_osc = wr_in && addr_in == ADDR_OSC_CTRL;
    assign key_a  = wr_osc && wdata_in[7:0] == KEY_FIRST;
    assign key_b  = wr_osc && wdata_in[7:0] == KEY_SECOND;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // The third write must not itself look like a restart of the key
    sequence key_set;
        key_a ##1 key_b ##1 (wr_osc && wdata_in[LOCK_BIT] && !key_a);
    endsequence

    sequence key_clear;
        key_b ##1 (wr_osc && !wdata_in[LOCK_BIT]);
    endsequence

    chk_lock_set: assert property (
        key_set ##1 rd_osc |=> rdata_out[LOCK_BIT]) else $error("lock not set by key");
    chk_key_clear: assert property (
        rd_osc ##1 (!rdata_out[ONE_WAY_BIT] && key_a) ##1 key_clear ##1 rd_osc
        |=> !rdata_out[LOCK_BIT]) else $error("lock not cleared by key");
    chk_lock_hold: assert property (
        rd_osc ##1 rd_osc |=> rdata_out[LOCK_BIT] == $past(rdata_out[LOCK_BIT]))
        else $error("lock changed on its own");
    chk_locked_write: assert property (
        (rd_in && addr_in == ADDR_OUT_MAP0) ##1 rd_osc
        ##1 (rdata_out[LOCK_BIT] && wr_in && addr_in == ADDR_OUT_MAP0)
        ##1 (rd_in && addr_in == ADDR_OUT_MAP0) |=> rdata_out == $past(rdata_out, 3))
        else $error("locked map write took effect");
    chk_one_way: assert property (
        rd_osc ##1 (rdata_out[LOCK_BIT] && rdata_out[ONE_WAY_BIT] && key_a)
        ##1 key_clear ##1 rd_osc |=> rdata_out[LOCK_BIT]) else $error("one-way lock cleared");
    chk_key_cancel: assert property (
        rd_osc ##1 (!rdata_out[LOCK_BIT] && key_a) ##1 rd_in ##1 key_b
        ##1 (wr_osc && wdata_in[LOCK_BIT]) ##1 rd_osc |=> !rdata_out[LOCK_BIT])
        else $error("cancelled key still armed");
    chk_analog_reset: assert property (
        $rose(reset_n_in) |-> (pin_read_out == 8'h00 && pad_oe_out == 8'h00) [*2])
        else $error("pins not analog after reset");
    chk_no_mismatch: assert property (
        !mismatch_reset_out) else $error("mismatch reset without disturbance");
endmodule

bind rpmlk_top rpmlk_asserts u_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_read_out(pin_read_out),
    .pad_oe_out(pad_oe_out), .mismatch_reset_out(mismatch_reset_out));

`default_nettype wire

// ---- tb/rpmlk_far_side.sv ----
// Pads and peripherals beyond the mux: resolves each pad from its drivers.
// Assumes the bench chooses board levels and peripheral output levels.
`default_nettype none

module rpmlk_far_side
    import rpmlk_pkg::*;
(
    // Block side
    input  wire logic [PIN_COUNT-1:0] pad_out_in,
    input  wire logic [PIN_COUNT-1:0] pad_oe_in,
    // Levels chosen by the bench
    input  wire logic [PIN_COUNT-1:0] board_level_in,
    input  wire rpmlk_periph_out_t    periph_level_in,
    // To the block
    output logic      [PIN_COUNT-1:0] pad_level_out,
    output rpmlk_periph_out_t         periph_outputs_out
);
    // A driven pad reads back its own drive; an undriven one shows the board
    assign pad_level_out      = (pad_oe_in & pad_out_in) | (~pad_oe_in & board_level_in);
    assign periph_outputs_out = periph_level_in;
endmodule

`default_nettype wire

// ---- tb/rpmlk_top_tb.sv ----
// Register-level bench for the pin output mux: selector codes, lock, key and pins.
// Assumes the far-side model and the bound checker; one 20 MHz clock.
`default_nettype none

module rpmlk_top_tb
    import rpmlk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk_in;
    logic                 reset_n_in;
    logic [ADDR_W-1:0]    addr_in;
    logic [DATA_W-1:0]    wdata_in;
    logic                 wr_in;
    logic                 rd_in;
    logic [DATA_W-1:0]    rdata_out;
    logic [DATA_W-1:0]    rd_data;
    logic [CFG_W-1:0]     osc_config_word_in;
    rpmlk_periph_out_t    periph_outputs_in;
    rpmlk_periph_out_t    periph_level;
    rpmlk_periph_in_t     periph_in_seen;
    logic [PIN_COUNT-1:0] port_data_in;
    logic [PIN_COUNT-1:0] direction_reg_in;
    logic [PIN_COUNT-1:0] pin_read_out;
    logic [PIN_COUNT-1:0] pad_in;
    logic [PIN_COUNT-1:0] pad_out;
    logic [PIN_COUNT-1:0] pad_oe_out;
    logic [PIN_COUNT-1:0] board_level;
    logic                 irq_out;
    logic                 mismatch_reset_out;
    int                   num_errors = 0;
    int                   check_count = 0;
    logic [SEL_W-1:0]     codes [10] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12,
                                         5'h13, 5'h01, 5'h1e};
    int                   src [10] = '{7, 6, 5, 4, 3, 2, 1, 0, 7, 7};

    rpmlk_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .osc_config_word_in(osc_config_word_in), .periph_outputs_in(periph_outputs_in),
        .periph_inputs_out(periph_in_seen), .port_data_in(port_data_in),
        .direction_reg_in(direction_reg_in), .pin_read_out(pin_read_out), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_out(pad_oe_out), .irq_out(irq_out),
        .mismatch_reset_out(mismatch_reset_out));

    rpmlk_far_side u_far (.pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
        .board_level_in(board_level), .periph_level_in(periph_level),
        .pad_level_out(pad_in), .periph_outputs_out(periph_outputs_in));

    task automatic report_and_stop();
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // Every access starts just after an edge and leaves its strobe up for the next one
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        rd_in    <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        addr_in <= a;
        wr_in   <= 1'b0;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        #1;
        rd_data = rdata_out;
    endtask

    task automatic rdx(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        rd(a);
        chk_reg(rd_data, exp);
    endtask

    task automatic pause(input int n);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic key(input logic [DATA_W-1:0] d);
        wr(ADDR_OSC_CTRL, 16'h0046);
        wr(ADDR_OSC_CTRL, 16'h0057);
        wr(ADDR_OSC_CTRL, d);
    endtask

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    initial begin
        repeat (3000) @(posedge clk_in);
        num_errors++;
        report_and_stop();
    end

    initial begin
        reset_n_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        osc_config_word_in = 8'h20;
        periph_level = '0;
        port_data_in = 8'h00;
        direction_reg_in = 8'hff;
        board_level = 8'hff;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk_pin(pin_read_out, 8'h00);
        rdx(ADDR_OSC_CTRL, 16'h0020);
        rdx(ADDR_OUT_MAP0, 16'h0000);
        rdx(ADDR_IN_MAP0, 16'h1f1f);
        rdx(ADDR_ANALOG, 16'h00ff);
        wr(4'hf, 16'hffff);
        rdx(4'hf, 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h001f);
        wr(ADDR_ANALOG, 16'h0000);
        // Inverted then one-hot source, so a wrong source shows in one of the two passes
        for (int i = 0; i < 10; i++) begin
            for (int p = 0; p < 2; p++) begin
                periph_level <= p[0] ? rpmlk_periph_out_t'(7'h01 << src[i])
                                     : rpmlk_periph_out_t'(~(7'h01 << src[i]));
                port_data_in <= {7'h00, p[0]};
                direction_reg_in <= {7'h7f, ~p[0]};
                wr(ADDR_OUT_MAP0, {11'h000, codes[i]});
                pause(3);
                chk_pin(pad_oe_out, {7'h00, (src[i] < 7) | p[0]});
                chk_pin(pad_out & pad_oe_out, {7'h00, p[0]});
            end
        end
        direction_reg_in <= 8'hff;
        board_level <= 8'ha5;
        wr(ADDR_OUT_MAP0, 16'h0000);
        pause(8);
        chk_pin(pin_read_out, 8'ha5);
        wr(ADDR_OUT_MAP0, 16'h0003);
        wr(ADDR_ANALOG, 16'h0001);
        pause(8);
        chk_pin(pin_read_out, 8'ha4);
        chk_pin(pad_oe_out, 8'h00);
        key(16'h0040);
        rdx(ADDR_OSC_CTRL, 16'h0070);
        chk_pin({7'h00, irq_out}, 8'h01);
        rdx(ADDR_IRQ_STATUS, 16'h0002);
        pause(1);
        chk_pin({7'h00, irq_out}, 8'h00);
        rd(ADDR_OUT_MAP0);
        rd(ADDR_OSC_CTRL);
        wr(ADDR_OUT_MAP0, 16'h0007);
        rdx(ADDR_OUT_MAP0, 16'h0003);
        rdx(ADDR_IRQ_STATUS, 16'h0001);
        rd(ADDR_OSC_CTRL);
        key(16'h0000);
        rdx(ADDR_OSC_CTRL, 16'h0070);
        rdx(ADDR_IRQ_STATUS, 16'h0004);
        osc_config_word_in <= 8'h00;
        pause(6);
        rdx(ADDR_OSC_CTRL, 16'h0050);
        key(16'h0000);
        rdx(ADDR_OSC_CTRL, 16'h0010);
        rdx(ADDR_IRQ_STATUS, 16'h0002);
        pause(20);
        rdx(ADDR_OSC_CTRL, 16'h0010);
        rdx(ADDR_OSC_CTRL, 16'h0010);
        wr(ADDR_OUT_MAP0, 16'h1307);
        wr(ADDR_IN_MAP0, 16'h0002);
        rdx(ADDR_OUT_MAP0, 16'h1307);
        pause(3);
        chk_pin(pad_oe_out, 8'h02);
        chk_pin({4'h0, periph_in_seen}, 8'h08);
        rd(ADDR_OSC_CTRL);
        wr(ADDR_OSC_CTRL, 16'h0046);
        rd(ADDR_IRQ_MASK);
        wr(ADDR_OSC_CTRL, 16'h0057);
        wr(ADDR_OSC_CTRL, 16'h0040);
        rdx(ADDR_OSC_CTRL, 16'h0010);
        rdx(ADDR_IRQ_STATUS, 16'h0010);
        pause(1);
        chk_pin({7'h00, mismatch_reset_out}, 8'h00);
        report_and_stop();
    end
endmodule

`default_nettype wire
